// *** sim/sepio_link_asserts.sv ***
// Purpose: checks on the pins between the two link ends
// Assumes: one clock domain, pins sampled by clk
// Notes: read latency is loose, so windows are wide
`timescale 1ns/1ps
`default_nettype none
module sepio_link_asserts (
    // system
    input wire logic clk,
    input wire logic sys_rst,
    // link
    input wire logic inClk,
    input wire logic selectN,
    input wire logic writeCmdN,
    input wire logic refreshCmdN,
    input wire logic [sepio_pkg::ADDR_W-1:0] addressLines,
    input wire logic [sepio_pkg::BANK_W-1:0] bankSelect,
    input wire logic writeDataClock,
    input wire logic [sepio_pkg::DATA_W-1:0] readDataBus,
    input wire logic [1:0] readDataClock,
    input wire logic [1:0] readDataClockN,
    input wire logic readValid,
    input wire logic [sepio_pkg::UNUSED_W-1:0] unusedOe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    wire readCmd = !selectN && writeCmdN && refreshCmdN;
    wire cfgCmd = !selectN && !writeCmdN && !refreshCmdN;
    a_addr_stable: assert property ($rose(inClk) |-> $stable(addressLines) && $stable(bankSelect)) else $error("address moved at clock rise");
    a_cmd_held: assert property ($fell(selectN) |-> !selectN [*8]) else $error("command did not stand");
    a_dk_supplied: assert property (1'b1 |-> ##[1:20] $changed(writeDataClock)) else $error("data clock stopped");
    a_read_answered: assert property ($rose(inClk) && readCmd |-> ##[1:80] readValid) else $error("read gave no valid");
    a_qk0_runs: assert property (1'b1 |-> ##[1:40] $changed(readDataClock[0])) else $error("pair zero stopped");
    a_qk1_runs: assert property (1'b1 |-> ##[1:40] $changed(readDataClock[1])) else $error("pair one stopped");
    a_qk_complement: assert property (readDataClockN == ~readDataClock) else $error("pair not opposite");
    a_valid_aligned: assert property ($changed(readValid) |-> $changed(readDataClock)) else $error("valid off clock edge");
    a_data_on_edges: assert property (readValid && $stable(readDataClock) |-> $stable(readDataBus)) else $error("data moved off edge");
    a_valid_bounded: assert property ($rose(readValid) |-> ##[1:40] !readValid) else $error("valid stuck high");
    a_unused_off: assert property (unusedOe == '0) else $error("unused ball driven");
    c_read: cover property ($rose(inClk) && readCmd);
    c_cfg: cover property ($rose(inClk) && cfgCmd);
    c_valid: cover property ($rose(readValid));
endmodule : sepio_link_asserts
`default_nettype wire

// *** sim/test_sepio_dram_x18_pin_interface.sv ***
// Purpose: both link ends joined, plus a bench-driven second device
// Assumes: second link clock made here at 80 ns
// Notes: rows write, mask, read and configure through the controller
`timescale 1ns/1ps
`default_nettype none
module test_sepio_dram_x18_pin_interface;
    typedef struct packed {
        sepio_pkg::cmd_type cmd;
        logic [21:0] addr;
        logic [2:0] bank;
        logic [17:0] rise;
        logic [17:0] fall;
        logic [1:0] mask;
    } row_type;
    // read rows hold the expected words in rise and fall
    row_type rows [0:10] = '{
        '{sepio_pkg::CMD_CFG, 22'h000200, 3'h0, 18'h0, 18'h0, 2'h0},
        '{sepio_pkg::CMD_WRITE, 22'h000004, 3'h2, 18'h01234, 18'h02abc, 2'h0},
        '{sepio_pkg::CMD_READ, 22'h000004, 3'h2, 18'h01234, 18'h02abc, 2'h0},
        '{sepio_pkg::CMD_WRITE, 22'h000004, 3'h2, 18'h00555, 18'h03fff, 2'h2},
        '{sepio_pkg::CMD_READ, 22'h000004, 3'h2, 18'h00555, 18'h02abc, 2'h0},
        '{sepio_pkg::CMD_WRITE, 22'h000004, 3'h5, 18'h3c3c3, 18'h0f0f0, 2'h0},
        '{sepio_pkg::CMD_READ, 22'h000004, 3'h5, 18'h3c3c3, 18'h0f0f0, 2'h0},
        '{sepio_pkg::CMD_READ, 22'h000004, 3'h2, 18'h00555, 18'h02abc, 2'h0},
        '{sepio_pkg::CMD_WRITE, 22'h000004, 3'h5, 18'h0, 18'h0, 2'h3},
        '{sepio_pkg::CMD_READ, 22'h000004, 3'h5, 18'h3c3c3, 18'h0f0f0, 2'h0},
        '{sepio_pkg::CMD_CFG, 22'h3ffdff, 3'h0, 18'h0, 18'h0, 2'h0}
    };
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reqValid = 1'b0;
    sepio_pkg::cmd_type reqCmd = sepio_pkg::CMD_NOP;
    logic [21:0] reqAddr = '0;
    logic [2:0] reqBank = '0;
    logic [17:0] reqDataRise = '0;
    logic [17:0] reqDataFall = '0;
    logic [1:0] reqMask = '0;
    logic reqReady;
    logic [17:0] rdData;
    logic rdValid;
    logic odtOn;
    logic odtOn2;
    logic [21:0] cfgValue;
    logic refreshSeen2;
    int nMismatch = 0;
    int checkCount = 0;
    int cycles = 0;
    int nRefresh = 0;
    sepio_link_if link();
    sepio_link_if link2();
    sepio_ctrl_end sepio_ctrl_end_inst (.clk(clk), .sys_rst(sys_rst),
        .link(link), .reqValid(reqValid), .reqCmd(reqCmd),
        .reqAddr(reqAddr), .reqBank(reqBank), .reqDataRise(reqDataRise),
        .reqDataFall(reqDataFall), .reqMask(reqMask), .reqReady(reqReady),
        .rdData(rdData), .rdValid(rdValid));
    sepio_dram_end sepio_dram_end_inst (.clk(clk), .sys_rst(sys_rst),
        .link(link), .odtOn(odtOn), .cfgValue(cfgValue), .refreshSeen());
    // second device takes deliberately broken traffic from the bench
    sepio_dram_end sepio_dram_end_inst2 (.clk(clk), .sys_rst(sys_rst),
        .link(link2), .odtOn(odtOn2), .cfgValue(),
        .refreshSeen(refreshSeen2));
    sepio_link_asserts sepio_link_asserts_inst (.clk(clk),
        .sys_rst(sys_rst), .inClk(link.inClk), .selectN(link.selectN),
        .writeCmdN(link.writeCmdN), .refreshCmdN(link.refreshCmdN),
        .addressLines(link.addressLines), .bankSelect(link.bankSelect),
        .writeDataClock(link.writeDataClock),
        .readDataBus(link.readDataBus), .readDataClock(link.readDataClock),
        .readDataClockN(link.readDataClockN), .readValid(link.readValid),
        .unusedOe(link.unusedOe));
    always #2 clk = ~clk;
    // half period of ten clk cycles, moved just after a clk rise
    always begin
        repeat (10) @(posedge clk);
        #1;
        link2.inClk = ~link2.inClk;
        link2.writeDataClock = ~link2.writeDataClock;
    end
    always @(posedge clk) begin
        cycles++;
        if (refreshSeen2 === 1'b1) begin
            nRefresh++;
        end
        if (cycles == 20000) begin
            nMismatch++;
            finish_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            nMismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checkCount, nMismatch);
        if (nMismatch == 0 && checkCount > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    // entered and left one step after a clk rise
    task automatic issue(input row_type r);
        reqCmd = r.cmd;
        reqAddr = r.addr;
        reqBank = r.bank;
        reqDataRise = r.rise;
        reqDataFall = r.fall;
        reqMask = r.mask;
        reqValid = 1'b1;
        for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            #1;
            if (reqReady === 1'b1) break;
        end
        check(32'(reqReady), 32'h1);
        reqValid = 1'b0;
    endtask : issue
    task automatic get_read(output logic [17:0] w0, output logic [17:0] w1);
        int n;
        n = 0;
        w0 = 'x;
        w1 = 'x;
        for (int i = 0; i < 150 && n < 2; i++) begin
            @(posedge clk);
            #1;
            if (rdValid === 1'b1 && (n == 0 || rdData !== w0)) begin
                if (n == 0) w0 = rdData;
                else w1 = rdData;
                n++;
            end
        end
    endtask : get_read
    // pins change at the link clock fall, stand one period
    task automatic pin_cmd(input logic sel, input logic we, input logic rf);
        @(negedge link2.inClk);
        link2.selectN = sel;
        link2.writeCmdN = we;
        link2.refreshCmdN = rf;
        @(negedge link2.inClk);
        link2.selectN = 1'b1;
        link2.writeCmdN = 1'b1;
        link2.refreshCmdN = 1'b1;
        repeat (30) @(posedge clk);
    endtask : pin_cmd
    initial begin
        logic [17:0] w0;
        logic [17:0] w1;
        link2.inClk = 1'b0;
        link2.writeDataClock = 1'b0;
        link2.selectN = 1'b1;
        link2.writeCmdN = 1'b1;
        link2.refreshCmdN = 1'b1;
        link2.addressLines = 22'h000200;
        link2.bankSelect = 3'h0;
        link2.writeDataBus = 18'h0;
        link2.writeMask = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check(32'(link.selectN), 32'h1);
        check(32'(link.readValid), 32'h0);
        check(32'(odtOn), 32'(sepio_pkg::ODT_RESET));
        $display("reset test done");
        foreach (rows[i]) begin
            issue(rows[i]);
            if (rows[i].cmd == sepio_pkg::CMD_READ) begin
                get_read(w0, w1);
                check(32'(w0), 32'(rows[i].rise));
                check(32'(w1), 32'(rows[i].fall));
            end
            repeat (30) @(posedge clk);
            #1;
            if (rows[i].cmd == sepio_pkg::CMD_CFG) begin
                check(32'(cfgValue), 32'(rows[i].addr));
                check(32'(odtOn), 32'(rows[i].addr[9]));
                check(32'(link.unusedOe), 32'h0);
            end
            $display("row %0d done", i);
        end
        // second reset in mid-run clears the captured settings
        sys_rst = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check(32'(cfgValue), 32'h0);
        check(32'(link.selectN), 32'h1);
        check(32'(rdValid), 32'h0);
        $display("mid-run reset test done");
        // deselected commands must be dropped, a selected refresh taken
        pin_cmd(1'b1, 1'b0, 1'b0);
        check(32'(odtOn2), 32'(sepio_pkg::ODT_RESET));
        pin_cmd(1'b1, 1'b1, 1'b0);
        check(32'(nRefresh), 32'h0);
        pin_cmd(1'b0, 1'b1, 1'b0);
        check(32'(nRefresh), 32'h1);
        check(32'(link2.unusedOe), 32'h0);
        $display("select test done");
        finish_test();
    end
endmodule : test_sepio_dram_x18_pin_interface
`default_nettype wire

// *** verilog/sepio_ctrl_end.sv ***
// Purpose: controller end driving command, address and write data pins
// Assumes: user request held until reqReady pulses
// Notes: pin clocks are made here by a divider from clk
`timescale 1ns/1ps
`default_nettype none
module sepio_ctrl_end (
    // system
    input wire logic clk,
    input wire logic sys_rst,
    // link
    sepio_link_if.ctrl link,
    // user request
    input wire logic reqValid,
    input wire sepio_pkg::cmd_type reqCmd,
    input wire logic [sepio_pkg::ADDR_W-1:0] reqAddr,
    input wire logic [sepio_pkg::BANK_W-1:0] reqBank,
    input wire logic [sepio_pkg::DATA_W-1:0] reqDataRise,
    input wire logic [sepio_pkg::DATA_W-1:0] reqDataFall,
    input wire logic [1:0] reqMask,
    output logic reqReady,
    // read return
    output logic [sepio_pkg::DATA_W-1:0] rdData,
    output logic rdValid
);
    localparam int HALF = sepio_pkg::CLK_DIV / 2;
    logic [3:0] divCnt_r;
    logic clkOut_r;
    logic busy_r;
    logic selN_r, weN_r, rfN_r;
    logic [sepio_pkg::ADDR_W-1:0] addr_r;
    logic [sepio_pkg::BANK_W-1:0] bank_r;
    logic [sepio_pkg::DATA_W-1:0] dRise_r, dFall_r, dOut_r;
    logic [1:0] mask_r;
    logic maskOut_r;
    logic dkOut_r;
    logic [2:0] vSync_r;
    logic [sepio_pkg::DATA_W-1:0] q1_r, q2_r;
    wire halfTick = (divCnt_r == 4'(HALF - 1));
    wire fallTick = halfTick && clkOut_r;
    // read is select alone; only a config load pulls both command pins
    wire reqSel = reqCmd != sepio_pkg::CMD_NOP;
    wire reqWe = (reqCmd == sepio_pkg::CMD_WRITE) ||
        (reqCmd == sepio_pkg::CMD_CFG);
    wire reqRf = reqCmd == sepio_pkg::CMD_CFG;
    wire takeReq = reqValid && !busy_r && fallTick;
    // command launched at fall so it is stable at the next rising edge
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            divCnt_r <= 4'h0;
            clkOut_r <= 1'h0;
        end else begin
            divCnt_r <= halfTick ? 4'h0 : divCnt_r + 4'h1;
            if (halfTick) clkOut_r <= ~clkOut_r; // RQ8
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_r <= 1'h0;
            selN_r <= 1'h1;
            weN_r <= 1'h1;
            rfN_r <= 1'h1;
            addr_r <= '0;
            bank_r <= '0;
            dRise_r <= '0;
            dFall_r <= '0;
            mask_r <= 2'h3;
            reqReady <= 1'h0;
        end else begin
            reqReady <= takeReq;
            if (takeReq) begin
                busy_r <= 1'h1;
                selN_r <= !reqSel; // RQ5
                weN_r <= !reqWe; // RQ4
                rfN_r <= !reqRf; // RQ4
                addr_r <= reqAddr; // RQ1 RQ2 RQ14
                bank_r <= reqBank; // RQ3
                dRise_r <= reqDataRise;
                dFall_r <= reqDataFall;
                mask_r <= (reqCmd == sepio_pkg::CMD_WRITE) ? reqMask : 2'h3;
            end else if (fallTick) begin
                busy_r <= 1'h0;
                selN_r <= 1'h1;
                weN_r <= 1'h1;
                rfN_r <= 1'h1;
            end
        end
    end
    // write data launched two clk cycles before each data clock edge
    wire dLaunchR = (divCnt_r == 4'h0) && clkOut_r;
    wire dLaunchF = (divCnt_r == 4'h0) && !clkOut_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dOut_r <= '0;
            maskOut_r <= 1'h1;
            dkOut_r <= 1'h0;
        end else begin
            if (divCnt_r == 4'h2) dkOut_r <= clkOut_r; // RQ8
            if (dLaunchR) begin
                dOut_r <= dRise_r; // RQ6
                maskOut_r <= mask_r[0];
            end else if (dLaunchF) begin
                dOut_r <= dFall_r; // RQ6
                maskOut_r <= mask_r[1];
            end
        end
    end
    assign link.inClk = clkOut_r;
    assign link.writeDataClock = dkOut_r;
    assign link.selectN = selN_r; // RQ5
    assign link.writeCmdN = weN_r; // RQ4
    assign link.refreshCmdN = rfN_r; // RQ4
    assign link.addressLines = addr_r;
    assign link.bankSelect = bank_r;
    assign link.writeDataBus = dOut_r;
    assign link.writeMask = maskOut_r;
    // read capture: valid through three stages, data sampled alongside
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            vSync_r <= 3'h0;
            q1_r <= '0;
            q2_r <= '0;
            rdData <= '0;
            rdValid <= 1'h0;
        end else begin
            vSync_r <= {vSync_r[1:0], link.readValid};
            q1_r <= link.readDataBus;
            q2_r <= q1_r;
            if (vSync_r[2] == vSync_r[1]) rdValid <= vSync_r[2]; // RQ12
            rdData <= q2_r;
        end
    end
endmodule : sepio_ctrl_end
`default_nettype wire

// *** verilog/sepio_dram_end.sv ***
// Purpose: device end of the separate-io x18 dram pin link
// Assumes: link clocks far slower than clk, sampled through three flops
// Notes: small memory array stands in for the banks
// Operation
// RQ1 - address lines captured at input clock rise
// RQ2 - config load takes address lines as settings
// RQ3 - bank select picks target bank
// RQ4 - command decoded from write, refresh, select
// RQ5 - select high ignores commands, work continues
// RQ6 - write data sampled on both data clock edges
// RQ7 - mask high suppresses that data beat
// RQ8 - controller always supplies data clock
// RQ9 - read data driven on both edges
// RQ10 - output data clocks toggle continuously
// RQ11 - clock pair zero low half, one upper
// RQ12 - read valid marks data, edge aligned
// RQ13 - unused balls released when termination on
// RQ14 - termination bit loaded from address nine
`timescale 1ns/1ps
`default_nettype none
module sepio_dram_end #(
    parameter int DEPTH = sepio_pkg::MEM_DEPTH,
    parameter int QK_DIV = sepio_pkg::CLK_DIV
) (
    // system
    input wire logic clk,
    input wire logic sys_rst,
    // link
    sepio_link_if.device link,
    // status
    output logic odtOn,
    output logic [sepio_pkg::ADDR_W-1:0] cfgValue,
    output logic refreshSeen
);
    localparam int AW = sepio_pkg::MEM_AW;
    localparam int BW = sepio_pkg::BANK_W;
    localparam int EW = AW - BW;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WRITE = 2'b01,
        ST_READ = 2'b10
    } state_type;
    logic [sepio_pkg::DATA_W-1:0] mem [DEPTH];
    // three-flop samplers on every pin coming from the controller
    logic [2:0] ckS_r, dkS_r;
    logic [2:0] csS_r, weS_r, rfS_r, dmS_r;
    logic [sepio_pkg::ADDR_W-1:0] aS0_r, aS1_r, aS2_r;
    logic [BW-1:0] bS0_r, bS1_r, bS2_r;
    logic [sepio_pkg::DATA_W-1:0] dS0_r, dS1_r, dS2_r;
    logic ckLvl_r, dkLvl_r;
    // a level counts only once two stages agree, so a late edge is not split
    wire ckAgree = ckS_r[2] == ckS_r[1];
    wire dkAgree = dkS_r[2] == dkS_r[1];
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ckS_r <= 3'h0;
            dkS_r <= 3'h0;
            csS_r <= 3'h7;
            weS_r <= 3'h7;
            rfS_r <= 3'h7;
            dmS_r <= 3'h7;
            aS0_r <= '0;
            aS1_r <= '0;
            aS2_r <= '0;
            bS0_r <= '0;
            bS1_r <= '0;
            bS2_r <= '0;
            dS0_r <= '0;
            dS1_r <= '0;
            dS2_r <= '0;
            ckLvl_r <= 1'h0;
            dkLvl_r <= 1'h0;
        end else begin
            ckS_r <= {ckS_r[1:0], link.inClk};
            dkS_r <= {dkS_r[1:0], link.writeDataClock};
            csS_r <= {csS_r[1:0], link.selectN};
            weS_r <= {weS_r[1:0], link.writeCmdN};
            rfS_r <= {rfS_r[1:0], link.refreshCmdN};
            dmS_r <= {dmS_r[1:0], link.writeMask};
            aS0_r <= link.addressLines;
            aS1_r <= aS0_r;
            aS2_r <= aS1_r;
            bS0_r <= link.bankSelect;
            bS1_r <= bS0_r;
            bS2_r <= bS1_r;
            dS0_r <= link.writeDataBus;
            dS1_r <= dS0_r;
            dS2_r <= dS1_r;
            if (ckAgree) ckLvl_r <= ckS_r[2];
            if (dkAgree) dkLvl_r <= dkS_r[2];
        end
    end
    // edge seen once stages two and three agree on the new level
    wire ckRise = ckAgree && ckS_r[2] && !ckLvl_r;
    wire dkEdge = dkAgree && (dkS_r[2] != dkLvl_r);
    wire selOn = !csS_r[2]; // RQ5
    wire weOn = !weS_r[2];
    wire rfOn = !rfS_r[2];
    wire cmdWrite = ckRise && selOn && weOn && !rfOn; // RQ4
    wire cmdRefresh = ckRise && selOn && rfOn && !weOn; // RQ4
    wire cmdCfg = ckRise && selOn && rfOn && weOn; // RQ2 RQ4
    wire cmdRead = ckRise && selOn && !rfOn && !weOn; // RQ4
    wire [EW-1:0] colPart = aS2_r[EW-1:0];
    wire [AW-1:0] memAddr = {bS2_r, colPart}; // RQ1 RQ3
    state_type state_r, state_nxt;
    logic [AW-1:0] addr_r;
    logic [1:0] beat_r;
    logic [sepio_pkg::READ_LAT:0] rdPipe_r;
    logic [sepio_pkg::DATA_W-1:0] rdWord_r;
    // controller keeps the data clock running, so beats always arrive
    wire beatTake = (state_r == ST_WRITE) && dkEdge; // RQ8
    wire beatKeep = beatTake && !dmS_r[2]; // RQ7
    wire [AW-1:0] beatAddr = addr_r ^ AW'(beat_r[0]);
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (cmdWrite) state_nxt = ST_WRITE;
                else if (cmdRead) state_nxt = ST_READ;
            end
            // running operations finish regardless of select
            ST_WRITE: begin
                if (beatTake && beat_r[0]) state_nxt = ST_IDLE; // RQ5 RQ6
            end
            ST_READ: begin
                if (ckRise) state_nxt = ST_IDLE; // RQ5
            end
            default: state_nxt = ST_IDLE;
        endcase
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
            addr_r <= '0;
            beat_r <= 2'h0;
            odtOn <= sepio_pkg::ODT_RESET;
            cfgValue <= '0;
            refreshSeen <= 1'h0;
        end else begin
            state_r <= state_nxt;
            refreshSeen <= cmdRefresh;
            if (state_r == ST_IDLE && (cmdWrite || cmdRead)) begin
                addr_r <= memAddr;
                beat_r <= 2'h0;
            end else if (beatTake) begin
                beat_r <= beat_r + 2'h1;
            end
            if (cmdCfg && state_r == ST_IDLE) begin
                cfgValue <= aS2_r; // RQ2
                odtOn <= aS2_r[sepio_pkg::ODT_BIT]; // RQ14
            end
        end
    end
    always_ff @(posedge clk) begin
        if (beatKeep) mem[beatAddr] <= dS2_r; // RQ6 RQ7
    end
    // read side: output clocks free running from a divider of clk
    logic [3:0] qkCnt_r;
    logic qk_r;
    wire qkTick = (qkCnt_r == 4'(QK_DIV / 2 - 1));
    // a read starts one input clock later, costing a slot but easing timing
    wire rdStart = (state_r == ST_READ) && ckRise;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            qkCnt_r <= 4'h0;
            qk_r <= 1'h0;
            rdPipe_r <= '0;
            rdWord_r <= '0;
        end else begin
            qkCnt_r <= qkTick ? 4'h0 : qkCnt_r + 4'h1;
            if (qkTick) begin
                qk_r <= ~qk_r; // RQ10
                rdPipe_r <= {rdPipe_r[sepio_pkg::READ_LAT-1:0], 1'h0};
                if (rdPipe_r[0] || rdPipe_r[1]) begin
                    rdWord_r <= mem[addr_r ^ AW'(rdPipe_r[1])]; // RQ9
                end
            end
            if (rdStart) rdPipe_r[0] <= 1'h1;
        end
    end
    logic [sepio_pkg::DATA_W-1:0] qOut_r;
    logic qvOut_r;
    logic [1:0] qkOut_r, qkOutN_r;
    logic [sepio_pkg::UNUSED_W-1:0] dnuOe_r;
    // data, valid and clocks leave through one flop each so they stay aligned
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            qOut_r <= '0;
            qvOut_r <= 1'h0;
            qkOut_r <= 2'h0;
            qkOutN_r <= 2'h3;
            dnuOe_r <= '0;
        end else begin
            qOut_r <= rdWord_r; // RQ9 RQ11
            qvOut_r <= rdPipe_r[1] || rdPipe_r[2]; // RQ12
            qkOut_r <= {2{qk_r}}; // RQ10 RQ11
            qkOutN_r <= {2{~qk_r}}; // RQ10
            // with termination on the balls are never driven
            dnuOe_r <= '0; // RQ13
        end
    end
    assign link.readDataBus = qOut_r;
    assign link.readValid = qvOut_r;
    assign link.readDataClock = qkOut_r;
    assign link.readDataClockN = qkOutN_r;
    assign link.unusedOut = '0;
    assign link.unusedOe = dnuOe_r;
endmodule : sepio_dram_end
`default_nettype wire

// *** verilog/sepio_link_if.sv ***
// Purpose: pin bundle between controller and device
// Assumes: active-low pins carry the n suffix
// Notes: unusedOut and unusedOe are not resolved; the bench checks unusedOe only
`timescale 1ns/1ps
`default_nettype none
interface sepio_link_if;
    logic inClk;
    logic selectN;
    logic writeCmdN;
    logic refreshCmdN;
    logic [sepio_pkg::ADDR_W-1:0] addressLines;
    logic [sepio_pkg::BANK_W-1:0] bankSelect;
    logic writeDataClock;
    logic [sepio_pkg::DATA_W-1:0] writeDataBus;
    logic writeMask;
    logic [sepio_pkg::DATA_W-1:0] readDataBus;
    logic [1:0] readDataClock;
    logic [1:0] readDataClockN;
    logic readValid;
    logic [sepio_pkg::UNUSED_W-1:0] unusedOut;
    logic [sepio_pkg::UNUSED_W-1:0] unusedOe;
    modport device (
        input inClk, selectN, writeCmdN, refreshCmdN, addressLines,
        input bankSelect, writeDataClock, writeDataBus, writeMask,
        output readDataBus, readDataClock, readDataClockN, readValid,
        output unusedOut, unusedOe
    );
    modport ctrl (
        output inClk, selectN, writeCmdN, refreshCmdN, addressLines,
        output bankSelect, writeDataClock, writeDataBus, writeMask,
        input readDataBus, readDataClock, readDataClockN, readValid,
        input unusedOut, unusedOe
    );
endinterface : sepio_link_if
`default_nettype wire

// *** verilog/sepio_pkg.sv ***
// Purpose: shared constants for the separate-io x18 dram pin link
// Assumes: all pins sampled by clk at 250 MHz
// Notes: command codes are a simple coding of select, write and refresh
package sepio_pkg;
    localparam int ADDR_W = 22;
    localparam int BANK_W = 3;
    localparam int DATA_W = 18;
    localparam int HALF_W = 9;
    localparam int UNUSED_W = 4;
    localparam int ODT_BIT = 9;
    localparam logic [0:0] ODT_RESET = 1'h0;
    localparam int CLK_DIV = 10;
    localparam int MEM_DEPTH = 64;
    localparam int MEM_AW = 6;
    localparam int READ_LAT = 2;
    typedef enum logic [1:0] {
        CMD_NOP = 2'b00,
        CMD_WRITE = 2'b01,
        CMD_READ = 2'b10,
        CMD_CFG = 2'b11
    } cmd_type;
endpackage : sepio_pkg
